// ---- hdl/cfgp_pkg.sv ----
/*
 * constants, types and helpers shared by both ends of the configuration port
 * assumes a single 40 MHz clock on both ends; pins cross into each end through synchronisers
 */
// What this block does
// RULE1: selected only while low select low, high select high
// RULE2: write strobe low loads the eight-bit data byte
// RULE3: read strobe low turns upper five lines status
// RULE4: both strobes low: only the write counts
// RULE5: ready pin shows byte accept; mirrored on top line
// RULE6: status high means ready, low means busy
// RULE7: direction high reads, low writes into device
// RULE8: size 01 byte, 10 half, 00 word
// RULE9: burst flag low during burst, high single
// RULE10: continue high extends burst; low aborts it
// RULE11: device decodes the low eighteen host address bits
// RULE12: master mode drives 22-bit memory address
// RULE13: master mode ready pin is memory read strobe
// RULE14: busy high/low outputs held until configuration done
// RULE15: device pulls init low during stabilise and clear
// RULE16: init held low externally keeps device waiting
// RULE17: test clock or mode select held high
// RULE18: no scan selected: scan inhibited after configuration
// RULE19: configuration-only pins released to user afterwards
// RULE20: read strobe pin is host transfer strobe
// RULE21: strobes synchronised, each low pulse taken once
package cfgp_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int STAB_NS = 1000;
	localparam int CLEAR_NS = 2000;
	localparam logic [7:0] STAB_CYC = 8'((STAB_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] CLEAR_CYC = 8'((CLEAR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] BYTE_BUSY_CYC = 8'h04;
	localparam logic [7:0] MEM_STROBE_CYC = 8'h08;
	localparam logic [7:0] MEM_GAP_CYC = 8'h02;
	localparam logic [7:0] HOST_SETUP_CYC = 8'h02;
	localparam logic [7:0] HOST_STROBE_CYC = 8'h08;
	localparam logic [7:0] HOST_GAP_CYC = 8'h04;

	// ----------------------------------------------------------------
	// widths and fields
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int HADDR_W = 18;
	localparam int MADDR_W = 22;
	localparam logic [7:0] OE_STATUS = 8'hf8;
	localparam logic [7:0] OE_ALL = 8'hff;
	localparam logic [7:0] OE_NONE = 8'h00;
	localparam logic [2:0] STATUS_PAD = 3'h0;
	localparam logic [1:0] TSZ_WORD = 2'h0;
	localparam logic [1:0] TSZ_BYTE = 2'h1;
	localparam logic [1:0] TSZ_HALF = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CFGP_MODE_PERIPH = 2'h0,
		CFGP_MODE_MASTER = 2'h1,
		CFGP_MODE_HOST = 2'h2
	} cfgp_mode_type;

	typedef enum logic [2:0] {
		DST_STAB = 3'h0,
		DST_CLEAR = 3'h1,
		DST_WAIT = 3'h3,
		DST_LOAD = 3'h2,
		DST_DONE = 3'h6
	} cfgp_dstate_type;

	typedef enum logic [1:0] {
		HST_IDLE = 2'h0,
		HST_SETUP = 2'h1,
		HST_STROBE = 2'h3,
		HST_GAP = 2'h2
	} cfgp_hstate_type;

	typedef enum logic [1:0] {
		OP_PWRITE = 2'h0,
		OP_PSTATUS = 2'h1,
		OP_HWRITE = 2'h2,
		OP_HREAD = 2'h3
	} cfgp_op_type;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] cfgp_size_bytes(input logic [1:0] tsz);
		case (tsz)
			TSZ_BYTE: cfgp_size_bytes = 3'h1;
			TSZ_HALF: cfgp_size_bytes = 3'h2;
			default: cfgp_size_bytes = 3'h4;
		endcase
	endfunction

endpackage

// ---- hdl/cfgp_if.sv ----
/*
 * pin bundle between the configuration device and its outside party
 * assumes the bench joins both ends; pull-ups are modelled as a high default
 */
`timescale 1ns/1ps
`default_nettype none
interface cfgp_if import cfgp_pkg::*; ();
	// ----------------------------------------------------------------
	// pins driven by the outside party
	// ----------------------------------------------------------------
	logic select_low_input_n;
	logic select_high_input;
	logic wr_dir;
	logic host_transfer_strobe_n;
	logic [HADDR_W-1:0] host_address_bus;
	logic [1:0] host_transfer_size;
	logic host_burst_flag_n;
	logic host_burst_continue;
	logic test_clk;
	logic test_mode_sel;
	logic [1:0] cfg_mode;
	logic [DATA_W-1:0] host_d_o;
	logic [DATA_W-1:0] host_d_oe;
	logic host_init_o;
	logic host_init_oe;
	// ----------------------------------------------------------------
	// pins driven by the device
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] dev_d_o;
	logic [DATA_W-1:0] dev_d_oe;
	logic dev_init_o;
	logic dev_init_oe;
	logic [MADDR_W-1:0] mem_addr;
	logic ready_rclk;
	logic config_busy_high_out;
	logic config_busy_low_out;
	// ----------------------------------------------------------------
	// resolved shared wires
	// ----------------------------------------------------------------
	wire logic [DATA_W-1:0] d;
	wire logic init_n;
	assign d = (dev_d_oe & dev_d_o) | (~dev_d_oe & host_d_oe & host_d_o) | (~dev_d_oe & ~host_d_oe);
	assign init_n = ~((dev_init_oe & ~dev_init_o) | (host_init_oe & ~host_init_o));

	modport dev (
		input select_low_input_n, select_high_input, wr_dir, host_transfer_strobe_n,
		input host_address_bus, host_transfer_size, host_burst_flag_n, host_burst_continue,
		input test_clk, test_mode_sel, cfg_mode, d, init_n,
		output dev_d_o, dev_d_oe, dev_init_o, dev_init_oe, mem_addr, ready_rclk,
		output config_busy_high_out, config_busy_low_out
	);
	modport host (
		output select_low_input_n, select_high_input, wr_dir, host_transfer_strobe_n,
		output host_address_bus, host_transfer_size, host_burst_flag_n, host_burst_continue,
		output test_clk, test_mode_sel, cfg_mode, host_d_o, host_d_oe, host_init_o, host_init_oe,
		input d, init_n, mem_addr, ready_rclk, config_busy_high_out, config_busy_low_out
	);
endinterface
`default_nettype wire

// ---- hdl/cfgp_device.sv ----
/*
 * device end: configuration sequencer, peripheral byte port, master memory fetch, host bus slave
 * assumes pins arrive asynchronously and the far end keeps strobes low for several clocks
 */
`timescale 1ns/1ps
`default_nettype none
module cfgp_device import cfgp_pkg::*; #(
	parameter int CFG_BYTES = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// pins
	cfgp_if.dev pins,
	// configuration stream
	output logic [DATA_W-1:0] cfg_byte,
	output logic cfg_byte_valid,
	output logic cfg_done,
	output logic scan_inhibit,
	output logic user_io_release,
	input wire logic scan_used,
	// host bus user side
	output logic hb_wr_valid,
	output logic hb_rd_valid,
	output logic [HADDR_W-1:0] hb_addr,
	output logic [DATA_W-1:0] hb_wr_data,
	input wire logic [DATA_W-1:0] hb_rd_data
);
	localparam int SYNC_W = 7 + 2 + DATA_W + HADDR_W + 2;
	localparam logic [15:0] CFG_LAST = 16'(CFG_BYTES);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic cs_n_s, cs1_s, wr_s, rd_s, init_s, burst_n_s, cont_s;
	logic [1:0] tsz_s;
	logic [1:0] mode_s;
	logic [DATA_W-1:0] d_s;
	logic [HADDR_W-1:0] addr_s;

	assign sync_in = {pins.select_low_input_n, pins.select_high_input, pins.wr_dir,
		pins.host_transfer_strobe_n, pins.init_n, pins.host_burst_flag_n,
		pins.host_burst_continue, pins.host_transfer_size, pins.d,
		pins.host_address_bus, pins.cfg_mode};
	assign {cs_n_s, cs1_s, wr_s, rd_s, init_s, burst_n_s, cont_s, tsz_s, d_s, addr_s, mode_s} =
		sync2_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= '1;
			sync2_r <= '1;
		end else begin
			sync1_r <= sync_in; // RULE21
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	cfgp_dstate_type state_r;
	cfgp_mode_type mode_r;
	logic [7:0] cnt_r;
	logic [7:0] lcnt_r;
	logic [15:0] byte_cnt_r;
	logic ready_r, mstrobe_r, pwr_prev_r, strb_prev_r;
	logic selected, periph_wr, periph_rd, host_strobe, wr_fall, strb_fall;
	logic loading, is_periph, is_master, is_host, host_live, all_in;
	logic take_byte, periph_stat, host_rd, hb_beat, mem_flip;

	assign selected = ~cs_n_s & cs1_s; // RULE1
	assign periph_wr = selected & ~wr_s; // RULE2
	assign periph_rd = selected & ~rd_s & wr_s; // RULE4
	assign host_strobe = selected & ~rd_s; // RULE20
	assign wr_fall = periph_wr & ~pwr_prev_r; // RULE21
	assign strb_fall = host_strobe & ~strb_prev_r;
	assign loading = (state_r == DST_LOAD);
	assign is_periph = (mode_r == CFGP_MODE_PERIPH);
	assign is_master = (mode_r == CFGP_MODE_MASTER);
	assign is_host = (mode_r == CFGP_MODE_HOST);
	assign host_live = is_host & (loading | (state_r == DST_DONE));
	assign all_in = (byte_cnt_r == CFG_LAST);
	assign take_byte = loading & is_periph & wr_fall & ready_r & ~all_in;
	assign periph_stat = loading & is_periph & periph_rd; // RULE3
	assign host_rd = host_live & host_strobe & wr_s; // RULE7
	assign hb_beat = host_live & strb_fall;
	assign mem_flip = loading & is_master & ~all_in &
		(lcnt_r == (mstrobe_r ? MEM_STROBE_CYC : MEM_GAP_CYC) - 8'h01);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_prev_r <= 1'b0;
			strb_prev_r <= 1'b0;
		end else begin
			pwr_prev_r <= periph_wr;
			strb_prev_r <= host_strobe;
		end
	end

	// ----------------------------------------------------------------
	// configuration sequencer
	// ----------------------------------------------------------------
	logic init_oe_r, busy_high_r, busy_low_r, scan_inh_r, user_io_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= DST_STAB;
			mode_r <= CFGP_MODE_PERIPH;
			cnt_r <= 8'h00;
			init_oe_r <= 1'b1;
		end else begin
			case (state_r)
				DST_STAB: begin
					mode_r <= cfgp_mode_type'(mode_s);
					cnt_r <= (cnt_r == STAB_CYC - 8'h01) ? 8'h00 : cnt_r + 8'h01;
					if (cnt_r == STAB_CYC - 8'h01)
						state_r <= DST_CLEAR;
				end
				DST_CLEAR: begin
					cnt_r <= (cnt_r == CLEAR_CYC - 8'h01) ? 8'h00 : cnt_r + 8'h01;
					if (cnt_r == CLEAR_CYC - 8'h01) begin
						state_r <= DST_WAIT;
						init_oe_r <= 1'b0; // RULE15
					end
				end
				DST_WAIT: if (init_s) begin
					state_r <= DST_LOAD; // RULE16
				end
				DST_LOAD: if (all_in) begin
					state_r <= DST_DONE;
				end
				DST_DONE: state_r <= DST_DONE;
				default: state_r <= DST_STAB;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_high_r <= 1'b1;
			busy_low_r <= 1'b0;
			scan_inh_r <= 1'b0;
			user_io_r <= 1'b0;
		end else if (state_r == DST_DONE) begin
			busy_high_r <= 1'b0; // RULE14
			busy_low_r <= 1'b1;
			scan_inh_r <= ~scan_used; // RULE18
			user_io_r <= 1'b1; // RULE19
		end
	end

	// ----------------------------------------------------------------
	// byte intake: peripheral, master fetch, host writes
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] cfg_byte_r;
	logic cfg_valid_r;
	logic [MADDR_W-1:0] mem_addr_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_r <= 1'b0;
			mstrobe_r <= 1'b0;
			lcnt_r <= 8'h00;
			byte_cnt_r <= 16'h0000;
			cfg_byte_r <= 8'h00;
			cfg_valid_r <= 1'b0;
			mem_addr_r <= '0;
		end else begin
			cfg_valid_r <= 1'b0;
			if (state_r == DST_WAIT && init_s) begin
				ready_r <= is_periph; // RULE5
			end else if (take_byte) begin
				cfg_byte_r <= d_s; // RULE2
				cfg_valid_r <= 1'b1;
				byte_cnt_r <= byte_cnt_r + 16'h0001;
				ready_r <= 1'b0; // RULE6
				lcnt_r <= 8'h00;
			end else if (loading && is_periph && !ready_r) begin
				lcnt_r <= lcnt_r + 8'h01;
				if (lcnt_r == BYTE_BUSY_CYC - 8'h01 && !all_in)
					ready_r <= 1'b1;
			end else if (loading && is_master && !all_in) begin
				lcnt_r <= lcnt_r + 8'h01;
				if (mem_flip) begin
					lcnt_r <= 8'h00;
					mstrobe_r <= ~mstrobe_r; // RULE13
					if (mstrobe_r) begin
						cfg_byte_r <= d_s;
						cfg_valid_r <= 1'b1;
						byte_cnt_r <= byte_cnt_r + 16'h0001;
						mem_addr_r <= mem_addr_r + 22'h000001; // RULE12
					end
				end
			end else if (loading && hb_beat && !wr_s && !all_in) begin
				cfg_byte_r <= d_s;
				cfg_valid_r <= 1'b1;
				byte_cnt_r <= byte_cnt_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// host bus slave
	// ----------------------------------------------------------------
	logic hb_active_r, hb_burst_r, hb_wr_r, hb_rd_r;
	logic [2:0] hb_size_r, hb_unit_r;
	logic [7:0] hb_off_r;
	logic [HADDR_W-1:0] hb_base_r, hb_addr_r;
	logic [DATA_W-1:0] hb_data_r;
	logic [2:0] beat_size, beat_unit;
	logic [7:0] beat_off;
	logic [HADDR_W-1:0] beat_base;
	logic beat_burst, unit_end;

	assign beat_base = hb_active_r ? hb_base_r : addr_s; // RULE11
	assign beat_size = hb_active_r ? hb_size_r : cfgp_size_bytes(tsz_s); // RULE8
	assign beat_burst = hb_active_r ? hb_burst_r : ~burst_n_s; // RULE9
	assign beat_unit = hb_active_r ? hb_unit_r : 3'h0;
	assign beat_off = hb_active_r ? hb_off_r : 8'h00;
	assign unit_end = (beat_unit + 3'h1 == beat_size);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hb_active_r <= 1'b0;
			hb_burst_r <= 1'b0;
			hb_size_r <= 3'h0;
			hb_unit_r <= 3'h0;
			hb_off_r <= 8'h00;
			hb_base_r <= '0;
			hb_addr_r <= '0;
			hb_data_r <= 8'h00;
			hb_wr_r <= 1'b0;
			hb_rd_r <= 1'b0;
		end else begin
			hb_wr_r <= hb_beat & ~wr_s; // RULE7
			hb_rd_r <= hb_beat & wr_s;
			if (hb_beat) begin
				hb_addr_r <= beat_base + HADDR_W'(beat_off);
				hb_data_r <= d_s;
				hb_base_r <= beat_base;
				hb_size_r <= beat_size;
				hb_burst_r <= beat_burst;
				hb_off_r <= beat_off + 8'h01;
				hb_unit_r <= unit_end ? 3'h0 : beat_unit + 3'h1;
				hb_active_r <= ~(unit_end & ~(beat_burst & cont_s)); // RULE10
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] d_o_r, d_oe_r;
	logic rdy_pin_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			d_o_r <= 8'h00;
			d_oe_r <= OE_NONE;
			rdy_pin_r <= 1'b0;
		end else begin
			d_oe_r <= periph_stat ? OE_STATUS : (host_rd ? OE_ALL : OE_NONE); // RULE3
			d_o_r <= periph_stat ? {ready_r, init_s, loading, is_periph, all_in, STATUS_PAD} :
				hb_rd_data; // RULE5
			rdy_pin_r <= !loading ? 1'b1 : (is_master ? ~(mstrobe_r ^ mem_flip) : ready_r); // RULE13
		end
	end

	assign pins.dev_d_o = d_o_r;
	assign pins.dev_d_oe = d_oe_r;
	assign pins.dev_init_o = 1'b0;
	assign pins.dev_init_oe = init_oe_r;
	assign pins.mem_addr = mem_addr_r;
	assign pins.ready_rclk = rdy_pin_r;
	assign pins.config_busy_high_out = busy_high_r;
	assign pins.config_busy_low_out = busy_low_r;
	assign cfg_byte = cfg_byte_r;
	assign cfg_byte_valid = cfg_valid_r;
	assign cfg_done = busy_low_r;
	assign scan_inhibit = scan_inh_r;
	assign user_io_release = user_io_r;
	assign hb_wr_valid = hb_wr_r;
	assign hb_rd_valid = hb_rd_r;
	assign hb_addr = hb_addr_r;
	assign hb_wr_data = hb_data_r;
endmodule
`default_nettype wire

// ---- hdl/cfgp_host.sv ----
/*
 * outside party: issues peripheral and host bus cycles and serves master-mode memory reads
 * assumes the device end samples pins through two-flop synchronisers
 */
`timescale 1ns/1ps
`default_nettype none
module cfgp_host import cfgp_pkg::*; #(
	parameter int MEM_AW = 6
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// pins
	cfgp_if.host pins,
	// command
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [HADDR_W-1:0] cmd_addr,
	input wire logic [DATA_W-1:0] cmd_data,
	input wire logic [1:0] cmd_size,
	input wire logic cmd_burst,
	input wire logic [7:0] cmd_units,
	output logic cmd_ready,
	// answer
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	output logic cfg_seen_done,
	// straps and init hold
	input wire logic hold_init,
	input wire logic [1:0] cfg_mode_sel,
	// configuration memory image
	input wire logic mem_we,
	input wire logic [MEM_AW-1:0] mem_waddr,
	input wire logic [DATA_W-1:0] mem_wdata
);
	localparam int SYNC_W = 2 + DATA_W + MADDR_W;

	// ----------------------------------------------------------------
	// synchronisers and memory
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync1_r, sync2_r;
	logic rdy_s, done_s;
	logic [DATA_W-1:0] d_s;
	logic [MADDR_W-1:0] maddr_s;
	logic [DATA_W-1:0] mem [2**MEM_AW];

	assign {rdy_s, done_s, d_s, maddr_s} = sync2_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {pins.ready_rclk, pins.config_busy_low_out, pins.d, pins.mem_addr};
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (mem_we)
			mem[mem_waddr] <= mem_wdata;
	end

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	cfgp_hstate_type st_r;
	cfgp_op_type op_r;
	logic [7:0] cnt_r, left_r, beat_r;
	logic [DATA_W-1:0] data_r, rsp_r, d_o_r, d_oe_r;
	logic [1:0] mode_r;
	logic burst_r, cs_n_r, cs1_r, wr_r, strb_n_r, cont_r, rsp_v_r, ready_r, init_oe_r;
	logic is_pw, is_hw, is_rd, serve, setup_ok, last_beat;
	logic [7:0] cmd_beats;

	assign is_pw = (op_r == OP_PWRITE);
	assign is_hw = (op_r == OP_HWRITE);
	assign is_rd = (op_r == OP_PSTATUS) | (op_r == OP_HREAD);
	assign serve = (mode_r == CFGP_MODE_MASTER) & ~rdy_s & ~done_s;
	assign setup_ok = (cnt_r >= HOST_SETUP_CYC - 8'h01) & (~is_pw | rdy_s);
	assign last_beat = (left_r == 8'h01);
	assign cmd_beats = cmd_op[1] ? 8'(cmd_units * cfgp_size_bytes(cmd_size)) : 8'h01;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= HST_IDLE;
			op_r <= OP_PWRITE;
			cnt_r <= 8'h00;
			left_r <= 8'h00;
			beat_r <= 8'h00;
			data_r <= 8'h00;
			rsp_r <= 8'h00;
			rsp_v_r <= 1'b0;
			ready_r <= 1'b0;
			burst_r <= 1'b0;
		end else begin
			rsp_v_r <= 1'b0;
			ready_r <= (st_r == HST_IDLE) & ~(cmd_valid & ready_r);
			cnt_r <= cnt_r + 8'h01;
			case (st_r)
				HST_IDLE: if (cmd_valid && ready_r) begin
					op_r <= cfgp_op_type'(cmd_op);
					data_r <= cmd_data;
					burst_r <= cmd_burst;
					left_r <= cmd_beats;
					beat_r <= 8'h00;
					cnt_r <= 8'h00;
					st_r <= HST_SETUP;
				end
				HST_SETUP: if (setup_ok) begin
					cnt_r <= 8'h00;
					st_r <= HST_STROBE;
				end
				HST_STROBE: if (cnt_r == HOST_STROBE_CYC - 8'h01) begin
					cnt_r <= 8'h00;
					rsp_r <= d_s;
					rsp_v_r <= is_rd & last_beat;
					st_r <= HST_GAP;
				end
				HST_GAP: if (cnt_r == HOST_GAP_CYC - 8'h01) begin
					cnt_r <= 8'h00;
					left_r <= left_r - 8'h01;
					beat_r <= beat_r + 8'h01;
					st_r <= last_beat ? HST_IDLE : HST_SETUP;
					rsp_v_r <= ~is_rd & last_beat;
				end
				default: st_r <= HST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	logic [HADDR_W-1:0] haddr_r;
	logic [1:0] tsz_r;
	logic burst_n_r;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_n_r <= 1'b1;
			cs1_r <= 1'b0;
			wr_r <= 1'b1;
			strb_n_r <= 1'b1;
			cont_r <= 1'b0;
			haddr_r <= '0;
			tsz_r <= TSZ_WORD;
			burst_n_r <= 1'b1;
			d_o_r <= 8'h00;
			d_oe_r <= OE_NONE;
			init_oe_r <= 1'b0;
			mode_r <= 2'h0;
		end else begin
			init_oe_r <= hold_init; // RULE16
			mode_r <= cfg_mode_sel;
			cs_n_r <= (st_r == HST_IDLE); // RULE1
			cs1_r <= (st_r != HST_IDLE);
			wr_r <= ~((st_r == HST_STROBE) & is_pw) & ~is_hw; // RULE7
			strb_n_r <= ~((st_r == HST_STROBE) & ~is_pw); // RULE20
			cont_r <= burst_r & ~last_beat; // RULE10
			burst_n_r <= ~burst_r; // RULE9
			if (st_r == HST_IDLE && cmd_valid && ready_r) begin
				haddr_r <= cmd_addr; // RULE11
				tsz_r <= cmd_size; // RULE8
			end
			d_o_r <= serve ? mem[maddr_s[MEM_AW-1:0]] : data_r + beat_r;
			d_oe_r <= (serve | ((st_r != HST_IDLE) & ~is_rd)) ? OE_ALL : OE_NONE; // RULE2
		end
	end

	assign pins.select_low_input_n = cs_n_r;
	assign pins.select_high_input = cs1_r;
	assign pins.wr_dir = wr_r;
	assign pins.host_transfer_strobe_n = strb_n_r;
	assign pins.host_address_bus = haddr_r;
	assign pins.host_transfer_size = tsz_r;
	assign pins.host_burst_flag_n = burst_n_r;
	assign pins.host_burst_continue = cont_r;
	assign pins.test_clk = 1'b1; // RULE17
	assign pins.test_mode_sel = 1'b1;
	assign pins.cfg_mode = mode_r;
	assign pins.host_d_o = d_o_r;
	assign pins.host_d_oe = d_oe_r;
	assign pins.host_init_o = 1'b0;
	assign pins.host_init_oe = init_oe_r;
	assign cmd_ready = ready_r;
	assign rsp_valid = rsp_v_r;
	assign rsp_data = rsp_r;
	assign cfg_seen_done = done_s;
endmodule
`default_nettype wire

// ---- bench/cfgp_assertions.sv ----
/* checker on the shared configuration pins
   assumes one clock domain and the pin bundle of cfgp_if */
`timescale 1ns/1ps
`default_nettype none
module cfgp_assertions import cfgp_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// pins
	input wire logic select_low_input_n,
	input wire logic select_high_input,
	input wire logic wr_dir,
	input wire logic [1:0] cfg_mode,
	input wire logic init_n,
	input wire logic [DATA_W-1:0] dev_d_o,
	input wire logic [DATA_W-1:0] dev_d_oe,
	input wire logic [MADDR_W-1:0] mem_addr,
	input wire logic ready_rclk,
	input wire logic config_busy_high_out,
	input wire logic config_busy_low_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire logic sel = !select_low_input_n && select_high_input;
	wire logic per = cfg_mode == CFGP_MODE_PERIPH;
	sequence s_idle;
		(!sel) [*5];
	endsequence
	sequence s_wr_start;
		$fell(wr_dir) && sel && per && ready_rclk && config_busy_high_out;
	endsequence
	property p_idle_quiet; s_idle |-> dev_d_oe == OE_NONE; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drive while unselected");
	property p_stat_lines; per |-> (dev_d_oe & ~OE_STATUS) == OE_NONE; endproperty
	a_stat_lines: assert property (p_stat_lines) else $error("low data lines driven");
	property p_stat_ready; per && dev_d_oe[7] |-> dev_d_o[7] == ready_rclk; endproperty
	a_stat_ready: assert property (p_stat_ready) else $error("top line not ready");
	property p_ready_busy; s_wr_start |-> ##[1:6] !ready_rclk; endproperty
	a_ready_busy: assert property (p_ready_busy) else $error("ready not low after byte");
	property p_busy_pair; config_busy_high_out != config_busy_low_out; endproperty
	a_busy_pair: assert property (p_busy_pair) else $error("progress outputs equal");
	property p_done_holds; config_busy_low_out |=> config_busy_low_out; endproperty
	a_done_holds: assert property (p_done_holds) else $error("done dropped");
	property p_init_stab; $fell(sys_rst) |-> (!init_n) [*8]; endproperty
	a_init_stab: assert property (p_init_stab) else $error("init not low after reset");
	property p_init_wait; !init_n |-> config_busy_high_out; endproperty
	a_init_wait: assert property (p_init_wait) else $error("done while init low");
	property p_addr_step; $changed(mem_addr) |-> mem_addr == $past(mem_addr) + 22'h1; endproperty
	a_addr_step: assert property (p_addr_step) else $error("memory address skipped");
	property p_addr_hold;
		cfg_mode == CFGP_MODE_MASTER && !ready_rclk |-> $stable(mem_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
endmodule
`default_nettype wire

// ---- bench/tb_config_and_host_port.sv ----
/* bench: both ends joined by the pin bundle, host end driven by commands
   assumes a 40 MHz clock and four configuration bytes */
`timescale 1ns/1ps
`default_nettype none
module tb_config_and_host_port import cfgp_pkg::*;;
	logic ref_clk = 1'h0, sys_rst = 1'h1, cmd_valid = 1'h0, cmd_burst = 1'h0, hold_init = 1'h1;
	logic mem_we = 1'h0, scan_used = 1'h0, cmd_ready, rsp_valid, seen_done, cfg_byte_valid;
	logic cfg_done, scan_inhibit, io_rel, hb_wr, hb_rd;
	logic [1:0] cmd_op = 2'h0, cmd_size = 2'h0, mode_sel = 2'h0;
	logic [17:0] cmd_addr = 18'h0, hb_addr;
	logic [7:0] cmd_data = 8'h0, cmd_units = 8'h1, mem_wdata = 8'h0, rd_data = 8'h5a;
	logic [7:0] rsp_data, cfg_byte, hb_wr_data;
	logic [5:0] mem_waddr = 6'h0;
	int failures = 0, checks_done = 0, nbytes = 0, nwr = 0, nrd = 0;
	cfgp_if pins();
	cfgp_device #(.CFG_BYTES(4)) cfgp_device_inst (.ref_clk, .sys_rst, .pins(pins.dev),
		.cfg_byte, .cfg_byte_valid, .cfg_done, .scan_inhibit, .user_io_release(io_rel),
		.scan_used, .hb_wr_valid(hb_wr), .hb_rd_valid(hb_rd), .hb_addr, .hb_wr_data,
		.hb_rd_data(rd_data));
	cfgp_host cfgp_host_inst (.ref_clk, .sys_rst, .pins(pins.host), .cmd_valid, .cmd_op,
		.cmd_addr, .cmd_data, .cmd_size, .cmd_burst, .cmd_units, .cmd_ready, .rsp_valid,
		.rsp_data, .cfg_seen_done(seen_done), .hold_init, .cfg_mode_sel(mode_sel), .mem_we,
		.mem_waddr, .mem_wdata);
	cfgp_assertions cfgp_assertions_inst (.ref_clk, .sys_rst,
		.select_low_input_n(pins.select_low_input_n), .select_high_input(pins.select_high_input),
		.wr_dir(pins.wr_dir), .cfg_mode(pins.cfg_mode), .init_n(pins.init_n),
		.dev_d_o(pins.dev_d_o), .dev_d_oe(pins.dev_d_oe), .mem_addr(pins.mem_addr),
		.ready_rclk(pins.ready_rclk), .config_busy_high_out(pins.config_busy_high_out),
		.config_busy_low_out(pins.config_busy_low_out));
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		nbytes += cfg_byte_valid;
		nwr += hb_wr;
		nrd += hb_rd;
	end
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(string name, logic [21:0] exp, logic [21:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic start(logic [1:0] m, logic su);
		sys_rst <= 1'h1;
		mode_sel <= m;
		scan_used <= su;
		tick(5);
		sys_rst <= 1'h0;
		nbytes = 0;
		nwr = 0;
		nrd = 0;
	endtask
	task automatic cmd(logic [1:0] op, logic [17:0] a, logic [7:0] dt, logic [1:0] sz,
		logic b, logic [7:0] u);
		int k;
		k = 0;
		while (cmd_ready !== 1'h1 && k < 500) begin
			tick(1);
			k++;
		end
		cmd_valid <= 1'h1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= dt;
		cmd_size <= sz;
		cmd_burst <= b;
		cmd_units <= u;
		tick(1);
		cmd_valid <= 1'h0;
		k = 0;
		while (rsp_valid !== 1'h1 && k < 2000) begin
			tick(1);
			k++;
		end
		chk("rsp_valid", 22'h1, {21'h0, rsp_valid});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		failures++;
		tally_and_finish();
	end
	initial begin
		start(CFGP_MODE_PERIPH, 1'h0);
		tick(300);
		chk("busy_held", 22'h1, {21'h0, pins.config_busy_high_out});
		hold_init <= 1'h0;
		tick(20);
		cmd(OP_PSTATUS, 18'h0, 8'h0, TSZ_BYTE, 1'h0, 8'h1);
		chk("status", 22'hf7, {14'h0, rsp_data});
		for (int i = 0; i < 4; i++) begin
			cmd(OP_PWRITE, 18'h0, 8'(8'h40 + i), TSZ_BYTE, 1'h0, 8'h1);
			chk("pbyte", 22'(8'h40 + i), {14'h0, cfg_byte});
		end
		chk("nbytes", 22'h4, 22'(nbytes));
		chk("done_io", 22'h3f, {16'h0, cfg_done, scan_inhibit, io_rel,
			pins.config_busy_low_out, ~pins.config_busy_high_out, seen_done});
		start(CFGP_MODE_MASTER, 1'h1);
		for (int i = 0; i < 4; i++) begin
			mem_we <= 1'h1;
			mem_waddr <= 6'(i);
			mem_wdata <= 8'(8'ha0 + i);
			tick(1);
		end
		mem_we <= 1'h0;
		for (int k = 0; k < 1000 && cfg_done !== 1'h1; k++) tick(1);
		chk("mbytes", 22'h4, 22'(nbytes));
		chk("mlast", 22'ha3, {14'h0, cfg_byte});
		chk("maddr", 22'h4, pins.mem_addr);
		chk("scan_on", 22'h0, {21'h0, scan_inhibit});
		start(CFGP_MODE_HOST, 1'h0);
		tick(150);
		cmd(OP_HWRITE, 18'h100, 8'h20, TSZ_WORD, 1'h0, 8'h1);
		chk("nwr_word", 22'h4, 22'(nwr));
		chk("wdata", 22'h23, {14'h0, hb_wr_data});
		cmd(OP_HWRITE, 18'h200, 8'h30, TSZ_HALF, 1'h1, 8'h2);
		chk("nwr_burst", 22'h8, 22'(nwr));
		chk("baddr", 22'h203, {4'h0, hb_addr});
		cmd(OP_HREAD, 18'h3ffff, 8'h0, TSZ_BYTE, 1'h0, 8'h1);
		chk("nrd", 22'h1, 22'(nrd));
		chk("rdata", 22'h5a, {14'h0, rsp_data});
		chk("raddr", 22'h3ffff, {4'h0, hb_addr});
		tally_and_finish();
	end
endmodule
`default_nettype wire
